/* dv/pre_host_model.sv */
// Purpose: host controller model for the two-wire register port
// Assumes: data line has a pull-up, so a released line reads high
// Notes: each clock high phase lasts HALF system cycles and each low phase twice that, above the three-cycle minimum
`timescale 1ns/1ps
module pre_host_model
  import pre_pkg::*;
#(
  parameter int HALF = 4
)
(
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wait_half();
    repeat (HALF) @(posedge clk);
  endtask
  // Data moves only while the clock is low, well clear of both edges
  task automatic bit_xfer(input logic v, output logic s);
    sda_drv <= v;
    wait_half();
    scl <= 1'b1;
    wait_half();
    s = sda_line;
    scl <= 1'b0;
    wait_half();
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    scl <= 1'b1;
    wait_half();
    sda_drv <= 1'b0;
    wait_half();
    scl <= 1'b0;
    wait_half();
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    wait_half();
    scl <= 1'b1;
    wait_half();
    sda_drv <= 1'b1;
    wait_half();
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, s);
    ok = !s;
  endtask
  // Protected register writes are sent whether or not the caller has unlocked; the target drops them while locked
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start();
    send_byte({PRE_DEV_ADDR, 1'b0}, k1);
    send_byte(a, k2);
    send_byte(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic k, s;
    start();
    send_byte({PRE_DEV_ADDR, 1'b0}, k);
    send_byte(a, k);
    stop();
    start();
    send_byte({PRE_DEV_ADDR, 1'b1}, k);
    for (int i = 0; i < 8; i++) begin
      bit_xfer(1'b1, s);
      d = {d[6:0], s};
    end
    bit_xfer(1'b1, s);
    stop();
  endtask
endmodule

/* dv/pre_regs_tb.sv */
// Purpose: self-checking bench for the rail enable and configuration bank
// Assumes: host model on the serial port, reference registers kept as integers
// Notes: timer parameters shortened so delay scenarios stay brief
`timescale 1ns/1ps
module pre_regs_tb;
  import pre_pkg::*;
  logic clock, rst, scl, sda_drv, sda_in, pw_unlocked, factory_seal, warm, seq_load, seq_sw1, seq_ldo;
  logic out1_in, out3_in, pb_pressed, rails_good, sda_oe, key_stb, linear_on, out1_oe, out2_out, out2_oe;
  logic out3_oe, warm_rst, pb_reset, power_good, tight, ov_en;
  logic [7:0] key_data;
  logic [4:0] seq_buck;
  logic [5:0] buck_on;
  logic [2:0] switch_on;
  logic [1:0] uv_thr;
  logic sda_out, out1_out, out3_out;
  // Shortened timers keep the delay scenarios brief
  localparam logic [31:0] T_PB_S = 32'h28;
  localparam logic [31:0] T_PB_L = 32'h4B;
  localparam logic [31:0] T_PG0 = 32'h5;
  localparam logic [31:0] T_PG1 = 32'hA;
  localparam logic [31:0] T_PG2 = 32'h19;
  localparam logic [31:0] T_PG3 = 32'h4B;
  int model[4];
  int pg_lim[4] = '{T_PG0, T_PG1, T_PG2, T_PG3};
  int n_mismatch = 0;
  int checks_done = 0;
  int n_key = 0;
  integer seed = 32'hDBC5446D;
  logic [7:0] r;
  assign sda_in = sda_drv & ~sda_oe;
  // Unlock strobe pulses, counted so stray ones on other addresses show up
  always @(posedge clock) if (key_stb === 1'b1) n_key <= n_key + 1;
  pre_host_model i_host (.clk(clock), .sda_line(sda_in), .scl(scl), .sda_drv(sda_drv));
  pre_regs #(.PB_SHORT_CYC(T_PB_S), .PB_LONG_CYC(T_PB_L), .PG0_CYC(T_PG0), .PG1_CYC(T_PG1),
    .PG2_CYC(T_PG2), .PG3_CYC(T_PG3)) i_dut (
    .CLOCK(clock), .RST(rst), .SCL(scl), .SDA_IN(sda_in), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .KEY_WR_STB(key_stb), .KEY_WR_DATA(key_data), .PW_UNLOCKED(pw_unlocked), .FACTORY_SEAL(factory_seal),
    .WARM_RST_ROUTE(warm), .SEQ_LOAD(seq_load), .SEQ_BUCK(seq_buck), .SEQ_SW1(seq_sw1), .SEQ_LDO(seq_ldo),
    .BUCK_ON(buck_on), .SWITCH_ON(switch_on), .LINEAR_ON(linear_on), .OUT1_IN(out1_in), .OUT1_OUT(out1_out),
    .OUT1_OE(out1_oe), .OUT2_OUT(out2_out), .OUT2_OE(out2_oe), .OUT3_IN(out3_in), .OUT3_OUT(out3_out),
    .OUT3_OE(out3_oe), .BUCK12_WARM_RESET(warm_rst), .PB_PRESSED(pb_pressed), .PB_RESET(pb_reset),
    .RAILS_GOOD(rails_good), .POWER_GOOD(power_good), .TIGHT_LIMITS(tight), .OV_MONITOR_EN(ov_en),
    .UNDERVOLTAGE_THRESHOLD(uv_thr));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic conclude();
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    i_host.write_reg(a, d, ok);
    check("ack", 32'(ok), 32'd1);
    if (pw_unlocked && a >= PRE_EN1_OFF && a <= PRE_CFG_OFF) begin
      if (a == PRE_EN1_OFF && factory_seal) d = d | (8'(model[1]) & PRE_SEAL_MASK);
      model[a - PRE_KEY_OFF] = d & (a == PRE_EN1_OFF ? PRE_EN1_MASK : a == PRE_EN2_OFF ? PRE_EN2_MASK : 8'hFF);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] d;
    i_host.read_reg(a, d);
    check("read", 32'(d), (a >= PRE_EN1_OFF && a <= PRE_CFG_OFF) ? 32'(model[a - PRE_KEY_OFF]) : 32'd0);
  endtask
  task automatic chk_outs();
    logic [7:0] e, c;
    logic lvl2;
    e = 8'(model[2]);
    c = 8'(model[3]);
    lvl2 = c[5] ? out1_in : e[5];
    check("buck", 32'(buck_on), 32'(model[1]));
    check("switch", 32'({switch_on, linear_on}), 32'(e[3:0]));
    check("out1_oe", 32'(out1_oe), 32'(!c[5] && !e[4]));
    check("out2_oe", 32'(out2_oe), 32'(c[6] | !lvl2));
    check("out2", 32'(out2_out), 32'(c[6] & lvl2));
    check("out3_oe", 32'(out3_oe), 32'(!warm && !e[6]));
    check("warm_rst", 32'(warm_rst), 32'(warm & !out3_in));
    check("supervisor", 32'({tight, ov_en, uv_thr}), 32'({c[2], c[2], c[1:0]}));
    check("const_outs", 32'({sda_out, out1_out, out3_out}), 32'd0);
  endtask
  // Counts edges until the chosen output rises; a miss ends the run
  task automatic wait_rise(input int sel, input int lim);
    int n;
    n = 0;
    while (n < lim + 4 && !(sel != 0 ? pb_reset : power_good)) begin
      @(posedge clock);
      n++;
    end
    check("delay", 32'(n >= lim && n <= lim + 2), 32'd1);
    if (n >= lim + 4) conclude();
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    conclude();
  end
  initial begin
    {rst, pw_unlocked, factory_seal, warm, seq_load, seq_buck, seq_sw1, seq_ldo} = 12'h800;
    {out1_in, out3_in, pb_pressed, rails_good} = 4'hC;
    model = '{0, 0, 0, 8};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int a = 16; a < 20; a++) rd(8'(a));
    rd(8'h20);
    chk_outs();
    wr(PRE_EN1_OFF, 8'h3F);
    rd(PRE_EN1_OFF);
    chk_outs();
    pw_unlocked <= 1'b1;
    r = 8'($random(seed));
    wr(PRE_KEY_OFF, r);
    check("key", 32'(key_data), 32'(r));
    check("key_stb", 32'(n_key), 32'd1);
    rd(PRE_KEY_OFF);
    wr(8'h20, 8'h5A);
    rd(8'h20);
    for (int i = 0; i < 9; i++) begin
      {out1_in, out3_in, warm} <= 3'($random(seed));
      wr(8'(PRE_EN1_OFF + i % 3), 8'($random(seed)));
      chk_outs();
      rd(8'(PRE_EN1_OFF + i % 3));
    end
    factory_seal <= 1'b1;
    wr(PRE_EN1_OFF, 8'h3F);
    wr(PRE_EN1_OFF, 8'h00);
    rd(PRE_EN1_OFF);
    factory_seal <= 1'b0;
    wr(PRE_EN1_OFF, 8'h00);
    rd(PRE_EN1_OFF);
    wr(PRE_EN1_OFF, 8'h20);
    @(posedge clock);
    {seq_buck, seq_sw1, seq_ldo} <= 7'($random(seed));
    seq_load <= 1'b1;
    @(posedge clock);
    seq_load <= 1'b0;
    model[1] = {model[1][5], seq_buck};
    model[2] = {model[2][7:2], seq_sw1, seq_ldo};
    repeat (2) @(posedge clock);
    chk_outs();
    rd(PRE_EN2_OFF);
    for (int t = 0; t < 2; t++) begin
      wr(PRE_CFG_OFF, {t[0], 7'h08});
      pb_pressed <= 1'b1;
      wait_rise(1, t != 0 ? T_PB_L : T_PB_S);
      @(posedge clock);
      check("pb_pulse", 32'(pb_reset), 32'd0);
      pb_pressed <= 1'b0;
    end
    for (int c = 0; c < 4; c++) begin
      wr(PRE_CFG_OFF, {3'h0, c[1:0], 3'h4});
      rails_good <= 1'b1;
      wait_rise(0, pg_lim[c]);
      rails_good <= 1'b0;
      repeat (2) @(posedge clock);
      check("pg_fall", 32'(power_good), 32'd0);
    end
    // Every buffer and routing combination, pin one level random
    for (int i = 0; i < 4; i++) begin
      {out1_in, out3_in, warm} <= 3'($random(seed));
      wr(PRE_CFG_OFF, {1'b0, i[1:0], 5'h08});
      chk_outs();
    end
    // Second reset in mid-run, then locked writes must be dropped
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    model = '{0, 0, 0, 8};
    @(posedge clock);
    for (int a = 17; a < 20; a++) rd(8'(a));
    chk_outs();
    pw_unlocked <= 1'b0;
    wr(PRE_CFG_OFF, 8'hFF);
    wr(PRE_EN2_OFF, 8'h7F);
    rd(PRE_CFG_OFF);
    rd(PRE_EN2_OFF);
    check("key_stb", 32'(n_key), 32'd1);
    chk_outs();
    conclude();
  end
endmodule

/* verilog/pre_pkg.sv */
// Purpose: constants and types shared by the rail enable and configuration register bank
// Assumes: 50 MHz system clock, byte-wide registers reached through a two-wire serial port
// Notes: device address is arbitrary; timing counts derive from the clock rate
package pre_pkg;

  // Arbitrary serial device address
  localparam logic [6:0] PRE_DEV_ADDR = 7'h30;

  localparam logic [7:0] PRE_KEY_OFF = 8'h10;
  localparam logic [7:0] PRE_EN1_OFF = 8'h11;
  localparam logic [7:0] PRE_EN2_OFF = 8'h12;
  localparam logic [7:0] PRE_CFG_OFF = 8'h13;

  localparam logic [7:0] PRE_KEY_RST = 8'h00;
  localparam logic [7:0] PRE_EN1_RST = 8'h00;
  localparam logic [7:0] PRE_EN2_RST = 8'h00;
  localparam logic [7:0] PRE_CFG_RST = 8'h08;

  // Writable bits; reserved bits read zero
  localparam logic [7:0] PRE_EN1_MASK = 8'h3F;
  localparam logic [7:0] PRE_EN2_MASK = 8'h7F;
  localparam logic [7:0] PRE_SEAL_MASK = 8'h30;

  localparam int PRE_SW1_BIT = 1;
  localparam int PRE_OUT1_BIT = 4;
  localparam int PRE_OUT2_BIT = 5;
  localparam int PRE_OUT3_BIT = 6;
  localparam int PRE_TIGHT_BIT = 2;
  localparam int PRE_PGD_LSB = 3;
  localparam int PRE_ROUTE_BIT = 5;
  localparam int PRE_BUF_BIT = 6;
  localparam int PRE_PBT_BIT = 7;

  localparam int PRE_CLK_HZ = 50_000_000;
  localparam int PRE_CLK_KHZ = PRE_CLK_HZ / 1000;
  localparam int PRE_PB_SHORT_S = 8;
  localparam int PRE_PB_LONG_S = 15;
  localparam int PRE_PG_MS0 = 10;
  localparam int PRE_PG_MS1 = 20;
  localparam int PRE_PG_MS2 = 50;
  localparam int PRE_PG_MS3 = 150;
  localparam logic [31:0] PRE_PB_SHORT_CYC = 32'(PRE_PB_SHORT_S * PRE_CLK_HZ);
  localparam logic [31:0] PRE_PB_LONG_CYC = 32'(PRE_PB_LONG_S * PRE_CLK_HZ);
  localparam logic [31:0] PRE_PG0_CYC = 32'(PRE_PG_MS0 * PRE_CLK_KHZ);
  localparam logic [31:0] PRE_PG1_CYC = 32'(PRE_PG_MS1 * PRE_CLK_KHZ);
  localparam logic [31:0] PRE_PG2_CYC = 32'(PRE_PG_MS2 * PRE_CLK_KHZ);
  localparam logic [31:0] PRE_PG3_CYC = 32'(PRE_PG_MS3 * PRE_CLK_KHZ);

  typedef enum logic [8:0] {
    PRE_S_IDLE = 9'h001,
    PRE_S_DEV = 9'h002,
    PRE_S_DACK = 9'h004,
    PRE_S_SUB = 9'h008,
    PRE_S_SACK = 9'h010,
    PRE_S_WR = 9'h020,
    PRE_S_WACK = 9'h040,
    PRE_S_RD = 9'h080,
    PRE_S_RACK = 9'h100
  } pre_ser_state_t;

endpackage

/* verilog/pre_regs.sv */
// Purpose: rail enable, output pin and supervisor configuration register bank
// Assumes: unlock sequence, seal and warm-reset routing bits are kept by neighbouring logic
// Notes: timer lengths are parameters so that simulation can shorten them
`timescale 1ns/1ps
module pre_regs
  import pre_pkg::*;
#(
  parameter logic [31:0] PB_SHORT_CYC = PRE_PB_SHORT_CYC,
  parameter logic [31:0] PB_LONG_CYC = PRE_PB_LONG_CYC,
  parameter logic [31:0] PG0_CYC = PRE_PG0_CYC,
  parameter logic [31:0] PG1_CYC = PRE_PG1_CYC,
  parameter logic [31:0] PG2_CYC = PRE_PG2_CYC,
  parameter logic [31:0] PG3_CYC = PRE_PG3_CYC
)
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic KEY_WR_STB,
  output logic [7:0] KEY_WR_DATA,
  input wire logic PW_UNLOCKED,
  input wire logic FACTORY_SEAL,
  input wire logic WARM_RST_ROUTE,
  input wire logic SEQ_LOAD,
  input wire logic [4:0] SEQ_BUCK,
  input wire logic SEQ_SW1,
  input wire logic SEQ_LDO,
  output logic [5:0] BUCK_ON,
  output logic [2:0] SWITCH_ON,
  output logic LINEAR_ON,
  input wire logic OUT1_IN,
  output logic OUT1_OUT,
  output logic OUT1_OE,
  output logic OUT2_OUT,
  output logic OUT2_OE,
  input wire logic OUT3_IN,
  output logic OUT3_OUT,
  output logic OUT3_OE,
  output logic BUCK12_WARM_RESET,
  input wire logic PB_PRESSED,
  output logic PB_RESET,
  input wire logic RAILS_GOOD,
  output logic POWER_GOOD,
  output logic TIGHT_LIMITS,
  output logic OV_MONITOR_EN,
  output logic [1:0] UNDERVOLTAGE_THRESHOLD
);
  logic wr_stb;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
  logic [7:0] en1_q, en1_d, en2_q, en2_d, cfg_q, cfg_d;
  logic o1_oe_q, o2_out_q, o2_oe_q, o3_oe_q, warm_q;
  logic pb_q, pg_q;
  logic [31:0] pb_cnt_q, pg_cnt_q;

  pre_serial_slave u_ser (
    .clk(CLOCK),
    .rst(RST),
    .scl(SCL),
    .sda_in(SDA_IN),
    .sda_oe(SDA_OE),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  assign SDA_OUT = 1'b0;
  assign KEY_WR_STB = wr_stb && (wr_addr == PRE_KEY_OFF);
  assign KEY_WR_DATA = wr_data;

  // Read mux; the key register never echoes what was written
  assign rd_data = (rd_addr == PRE_EN1_OFF) ? en1_q :
                   (rd_addr == PRE_EN2_OFF) ? en2_q :
                   (rd_addr == PRE_CFG_OFF) ? cfg_q : PRE_KEY_RST;

  wire wr_ok = wr_stb && PW_UNLOCKED;
  wire wr_en1 = wr_ok && (wr_addr == PRE_EN1_OFF);
  wire wr_en2 = wr_ok && (wr_addr == PRE_EN2_OFF);
  wire wr_cfg = wr_ok && (wr_addr == PRE_CFG_OFF);

  // Sealed backup bucks can be set but not cleared by software
  wire [7:0] keep1 = FACTORY_SEAL ? (en1_q & PRE_SEAL_MASK) : 8'h00;
  wire [7:0] host1 = wr_en1 ? ((wr_data & PRE_EN1_MASK) | keep1) : en1_q;
  wire [7:0] host2 = wr_en2 ? (wr_data & PRE_EN2_MASK) : en2_q;
  // Sequencer wins a same-cycle collision so the readback tracks the real rails
  assign en1_d = SEQ_LOAD ? {host1[7:5], SEQ_BUCK} : host1;
  assign en2_d = SEQ_LOAD ? {host2[7:2], SEQ_SW1, SEQ_LDO} : host2;
  assign cfg_d = wr_cfg ? wr_data : cfg_q;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      en1_q <= PRE_EN1_RST;
      en2_q <= PRE_EN2_RST;
      cfg_q <= PRE_CFG_RST;
    end else begin
      en1_q <= en1_d;
      en2_q <= en2_d;
      cfg_q <= cfg_d;
    end
  end

  assign BUCK_ON = en1_q[5:0];
  assign SWITCH_ON = en2_q[3:1];
  assign LINEAR_ON = en2_q[0];
  assign TIGHT_LIMITS = cfg_q[PRE_TIGHT_BIT];
  assign OV_MONITOR_EN = cfg_q[PRE_TIGHT_BIT];
  assign UNDERVOLTAGE_THRESHOLD = cfg_q[1:0];

  wire route = cfg_q[PRE_ROUTE_BIT];
  wire pushpull = cfg_q[PRE_BUF_BIT];
  // Pin one level drives pin two when routed
  wire out2_lvl = route ? OUT1_IN : en2_q[PRE_OUT2_BIT];
  wire o1_oe_d = ~route & ~en2_q[PRE_OUT1_BIT];
  wire o2_oe_d = pushpull | ~out2_lvl;
  wire o3_oe_d = ~WARM_RST_ROUTE & ~en2_q[PRE_OUT3_BIT];

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      o1_oe_q <= 1'b0;
      o2_out_q <= 1'b0;
      o2_oe_q <= 1'b0;
      o3_oe_q <= 1'b0;
      warm_q <= 1'b0;
    end else begin
      o1_oe_q <= o1_oe_d;
      o2_out_q <= pushpull & out2_lvl;
      o2_oe_q <= o2_oe_d;
      o3_oe_q <= o3_oe_d;
      warm_q <= WARM_RST_ROUTE & ~OUT3_IN;
    end
  end

  assign OUT1_OUT = 1'b0;
  assign OUT1_OE = o1_oe_q;
  assign OUT2_OUT = o2_out_q;
  assign OUT2_OE = o2_oe_q;
  assign OUT3_OUT = 1'b0;
  assign OUT3_OE = o3_oe_q;
  assign BUCK12_WARM_RESET = warm_q;

  wire [31:0] pb_lim = cfg_q[PRE_PBT_BIT] ? PB_LONG_CYC : PB_SHORT_CYC;
  wire [1:0] pgd = cfg_q[PRE_PGD_LSB +: 2];
  wire [31:0] pg_lim = (pgd == 2'h0) ? PG0_CYC :
                       (pgd == 2'h1) ? PG1_CYC :
                       (pgd == 2'h2) ? PG2_CYC : PG3_CYC;
  wire pb_hit = PB_PRESSED && (pb_cnt_q == pb_lim - 32'h1);
  wire pg_hit = RAILS_GOOD && !pg_q && (pg_cnt_q == pg_lim - 32'h1);

  // One reset pulse per press; a longer hold does not repeat it
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pb_cnt_q <= 32'h0;
      pb_q <= 1'b0;
    end else begin
      pb_q <= pb_hit;
      if (!PB_PRESSED) begin
        pb_cnt_q <= 32'h0;
      end else if (pb_cnt_q < pb_lim) begin
        pb_cnt_q <= pb_cnt_q + 32'h1;
      end
    end
  end
  assign PB_RESET = pb_q;

  // Rising edge waits out the delay; falling edge passes at once
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pg_cnt_q <= 32'h0;
      pg_q <= 1'b0;
    end else if (!RAILS_GOOD) begin
      pg_cnt_q <= 32'h0;
      pg_q <= 1'b0;
    end else if (!pg_q) begin
      pg_cnt_q <= pg_cnt_q + 32'h1;
      pg_q <= pg_hit;
    end
  end
  assign POWER_GOOD = pg_q;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_key_reads_zero: assert property (rd_addr == PRE_KEY_OFF |-> rd_data == 8'h00)
    else $error("unlock register read not zero");
  a_locked_write: assert property (wr_stb && !PW_UNLOCKED && !SEQ_LOAD |=> $stable(en1_q) && $stable(en2_q)
    && $stable(cfg_q))
    else $error("locked write changed a register");
  a_seal_backup: assert property (FACTORY_SEAL && en1_q[5] |=> en1_q[5])
    else $error("sealed backup buck cleared");
  a_seq_update: assert property (SEQ_LOAD |=> en1_q[4:0] == $past(SEQ_BUCK) && en2_q[PRE_SW1_BIT] == $past(SEQ_SW1)
    && LINEAR_ON == $past(SEQ_LDO))
    else $error("sequencer update lost");
  a_rail_follow: assert property (wr_en2 && !SEQ_LOAD |=> SWITCH_ON == $past(wr_data[3:1])
    && LINEAR_ON == $past(wr_data[0]))
    else $error("switch enables do not follow write");
  a_out3_drive: assert property (!WARM_RST_ROUTE && !en2_q[PRE_OUT3_BIT] ##1 !WARM_RST_ROUTE |-> OUT3_OE)
    else $error("pin three not driven low");
  a_out3_route: assert property (WARM_RST_ROUTE |=> !OUT3_OE)
    else $error("pin three driven while routed");
  a_out1_drive: assert property (!route |=> OUT1_OE == !$past(en2_q[PRE_OUT1_BIT]))
    else $error("pin one drive mismatch");
  a_pb_timer: assert property ($rose(PB_RESET) |-> $past(pb_cnt_q) == $past(pb_lim) - 32'h1)
    else $error("push-button reset at wrong count");
  a_out2_route: assert property (route && pushpull |=> OUT2_OE && OUT2_OUT == $past(OUT1_IN))
    else $error("routed push-pull pin two wrong");
  a_pg_fall: assert property (!RAILS_GOOD |=> !POWER_GOOD)
    else $error("power-good fall delayed");
  a_pg_rise: assert property ($rose(POWER_GOOD) |-> $past(pg_cnt_q) == $past(pg_lim) - 32'h1)
    else $error("power-good rise at wrong delay");
  a_tight_cfg: assert property (wr_cfg |=> OV_MONITOR_EN == $past(wr_data[PRE_TIGHT_BIT]))
    else $error("strictness not applied");
  a_warm_reset: assert property (WARM_RST_ROUTE && !OUT3_IN |=> BUCK12_WARM_RESET)
    else $error("warm reset not passed");
  a_buck_follow: assert property (wr_en1 && !SEQ_LOAD && !FACTORY_SEAL |=> BUCK_ON == $past(wr_data[5:0]))
    else $error("buck enables do not follow write");
  a_out2_drain: assert property (!pushpull |=> !OUT2_OUT && OUT2_OE == !$past(out2_lvl))
    else $error("open-drain pin two wrong");
endmodule

/* verilog/pre_serial_slave.sv */
// Purpose: two-wire serial target giving byte register access with auto-increment
// Assumes: line levels are synchronous to the clock and change far slower than it
// Notes: writes are subaddress then data bytes; reads continue from the last subaddress
`timescale 1ns/1ps
module pre_serial_slave
  import pre_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  pre_ser_state_t state_q;
  logic scl_q, sda_q, rw_q, oe_q, wr_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, ptr_q, wa_q, wd_q;

  wire rise = scl & ~scl_q;
  wire fall = ~scl & scl_q;
  wire start = scl & scl_q & sda_q & ~sda_in;
  wire stop = scl & scl_q & ~sda_q & sda_in;
  wire full = (cnt_q == 4'h8);
  wire [7:0] shin = {sh_q[6:0], sda_in};

  assign sda_oe = oe_q;
  assign wr_stb = wr_q;
  assign wr_addr = wa_q;
  assign wr_data = wd_q;
  assign rd_addr = ptr_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PRE_S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (start) begin
        state_q <= PRE_S_DEV;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (stop) begin
        state_q <= PRE_S_IDLE;
        oe_q <= 1'b0;
      end else begin
        case (state_q)
          PRE_S_DEV, PRE_S_SUB, PRE_S_WR: begin
            if (rise && !full) begin
              sh_q <= shin;
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && full) begin
              oe_q <= 1'b1;
              if (state_q == PRE_S_DEV) begin
                // Foreign address: stay silent until the next start
                state_q <= (sh_q[7:1] == PRE_DEV_ADDR) ? PRE_S_DACK : PRE_S_IDLE;
                oe_q <= (sh_q[7:1] == PRE_DEV_ADDR);
                rw_q <= sh_q[0];
              end else if (state_q == PRE_S_SUB) begin
                ptr_q <= sh_q;
                state_q <= PRE_S_SACK;
              end else begin
                wr_q <= 1'b1;
                wa_q <= ptr_q;
                wd_q <= sh_q;
                state_q <= PRE_S_WACK;
              end
            end
          end
          PRE_S_DACK, PRE_S_SACK, PRE_S_WACK, PRE_S_RACK: begin
            if (rise && state_q == PRE_S_RACK) begin
              ptr_q <= ptr_q + 8'h01;
              if (sda_in) begin
                state_q <= PRE_S_IDLE;
              end
            end else if (fall) begin
              cnt_q <= 4'h0;
              if ((state_q == PRE_S_DACK && rw_q) || state_q == PRE_S_RACK) begin
                sh_q <= rd_data;
                oe_q <= ~rd_data[7];
                state_q <= PRE_S_RD;
              end else begin
                oe_q <= 1'b0;
                if (state_q == PRE_S_WACK) begin
                  ptr_q <= ptr_q + 8'h01;
                end
                state_q <= (state_q == PRE_S_DACK) ? PRE_S_SUB : PRE_S_WR;
              end
            end
          end
          PRE_S_RD: begin
            if (rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (fall) begin
              if (full) begin
                oe_q <= 1'b0;
                state_q <= PRE_S_RACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                oe_q <= ~sh_q[6];
              end
            end
          end
          default: begin
            state_q <= PRE_S_IDLE;
          end
        endcase
      end
    end
  end
endmodule
